// >>> hw/ddsul_cfg.svh
// latency and layout constants for the update latency pipeline
// assumes a single system clock and a sync clock enable sampled from it
`ifndef DDSUL_CFG_SVH
`define DDSUL_CFG_SVH

// ----------------------------------------------------------------
// application latencies in system clock cycles
// ----------------------------------------------------------------
`define DDSUL_COMMIT_DAC_LAT    33
`define DDSUL_PROFILE_DAC_LAT   29
`define DDSUL_COMMIT_SHORT_LAT  4

// ----------------------------------------------------------------
// widths and reset values
// ----------------------------------------------------------------
`define DDSUL_FREQ_W     48
`define DDSUL_PHASE_W    14
`define DDSUL_CP_W       3
`define DDSUL_STEP_W     48
`define DDSUL_RATE_W     16
`define DDSUL_PROF_W     3
`define DDSUL_NPROF      8
`define DDSUL_CP_RST     3'h0

// ----------------------------------------------------------------
// AXI4-Lite register byte offsets
// ----------------------------------------------------------------
`define DDSUL_A_FREQ_LO   8'h00
`define DDSUL_A_FREQ_HI   8'h04
`define DDSUL_A_PHASE     8'h08
`define DDSUL_A_CP        8'h0C
`define DDSUL_A_STEP_LO   8'h10
`define DDSUL_A_STEP_HI   8'h14
`define DDSUL_A_RATE      8'h18
`define DDSUL_A_STATUS    8'h1C
`define DDSUL_A_PROF_BASE 8'h40
`define DDSUL_RESP_OKAY   2'h0
`define DDSUL_RESP_SLVERR 2'h2

`endif

// >>> hw/ddsul_pkg.sv
// types for the update latency pipeline
// assumes ddsul_cfg.svh is included first
`include "ddsul_cfg.svh"
package ddsul_pkg;
	typedef enum logic [1:0] {
		DDSUL_B_IDLE = 2'b00,
		DDSUL_B_RESP = 2'b01
	} ddsul_bus_type;

	typedef struct packed {
		// staged (written, not yet committed) values
		logic [`DDSUL_FREQ_W-1:0]  sf;
		logic [`DDSUL_PHASE_W-1:0] sp;
		logic [`DDSUL_CP_W-1:0]    scp;
		logic [`DDSUL_STEP_W-1:0]  sstep;
		logic [`DDSUL_RATE_W-1:0]  srate;
		// sync sampling
		logic                      upd_s;
		logic [`DDSUL_PROF_W-1:0]  prof_s;
		logic                      prof_v;
		// countdowns: 0 idle
		logic [5:0]                cnt_c;
		logic [5:0]                cnt_p;
		logic [2:0]                cnt_s;
		logic [`DDSUL_FREQ_W-1:0]  pend_f;
		logic [`DDSUL_PHASE_W-1:0] pend_p;
		logic [`DDSUL_CP_W-1:0]    pend_cp;
		logic [`DDSUL_STEP_W-1:0]  pend_step;
		logic [`DDSUL_RATE_W-1:0]  pend_rate;
		logic [`DDSUL_PROF_W-1:0]  pend_idx;
		// applied outputs
		logic [`DDSUL_FREQ_W-1:0]  dac_f;
		logic [`DDSUL_PHASE_W-1:0] dac_p;
		logic [`DDSUL_CP_W-1:0]    cp;
		logic [`DDSUL_STEP_W-1:0]  step;
		logic [`DDSUL_RATE_W-1:0]  rate;
		logic                      commit_p;
		logic                      profile_p;
		// bus
		ddsul_bus_type             wst;
		ddsul_bus_type             rst;
		logic [1:0]                bresp;
		logic [31:0]               rdata;
		logic [1:0]                rresp;
	} ddsul_state_type;
endpackage

// >>> hw/ddsul_top.sv
// update latency pipeline: commit strobe and profile pins to applied settings
// assumes strobe and profile pins are synchronous to core_clk and are
// examined only where sync_clk_rise marks a sync clock rising edge
`timescale 1ns/100ps
`include "ddsul_cfg.svh"
module ddsul_top #(
	parameter int COMMIT_LAT  = `DDSUL_COMMIT_DAC_LAT,
	parameter int PROFILE_LAT = `DDSUL_PROFILE_DAC_LAT,
	parameter int SHORT_LAT   = `DDSUL_COMMIT_SHORT_LAT
) (
	input  wire logic                      core_clk,
	input  wire logic                      srst,
	input  wire logic                      clk_en,
	input  wire logic                      sync_clk_rise,
	input  wire logic                      commit_strobe,
	input  wire logic [`DDSUL_PROF_W-1:0]  profile_select_pins,
	input  wire logic                      s_axi_awvalid,
	output logic                           s_axi_awready,
	input  wire logic [7:0]                s_axi_awaddr,
	input  wire logic                      s_axi_wvalid,
	output logic                           s_axi_wready,
	input  wire logic [31:0]               s_axi_wdata,
	input  wire logic [3:0]                s_axi_wstrb,
	output logic                           s_axi_bvalid,
	input  wire logic                      s_axi_bready,
	output logic [1:0]                     s_axi_bresp,
	input  wire logic                      s_axi_arvalid,
	output logic                           s_axi_arready,
	input  wire logic [7:0]                s_axi_araddr,
	output logic                           s_axi_rvalid,
	input  wire logic                      s_axi_rready,
	output logic [31:0]                    s_axi_rdata,
	output logic [1:0]                     s_axi_rresp,
	output logic [`DDSUL_FREQ_W-1:0]       dac_freq,
	output logic [`DDSUL_PHASE_W-1:0]      dac_phase,
	output logic [`DDSUL_CP_W-1:0]         charge_pump_output,
	output logic [`DDSUL_STEP_W-1:0]       sweep_step,
	output logic [`DDSUL_RATE_W-1:0]       sweep_rate,
	output logic                           commit_applied,
	output logic                           profile_applied
);
	localparam logic [5:0] CL = 6'(COMMIT_LAT);
	localparam logic [5:0] PL = 6'(PROFILE_LAT);
	localparam logic [2:0] SL = 3'(SHORT_LAT);

	ddsul_pkg::ddsul_state_type s_q;
	ddsul_pkg::ddsul_state_type s_d;

	// ----------------------------------------------------------------
	// profile memory, eight words of frequency and phase
	// ----------------------------------------------------------------
	logic [`DDSUL_FREQ_W-1:0]  prof_f_q [`DDSUL_NPROF];
	logic [`DDSUL_PHASE_W-1:0] prof_p_q [`DDSUL_NPROF];

	// handshake decode
	logic       wr_go;
	logic       rd_go;
	logic [7:0] pidx_w;
	assign wr_go  = s_q.wst == ddsul_pkg::DDSUL_B_IDLE && s_axi_awvalid && s_axi_wvalid;
	assign rd_go  = s_q.rst == ddsul_pkg::DDSUL_B_IDLE && s_axi_arvalid;
	assign pidx_w = s_axi_awaddr - `DDSUL_A_PROF_BASE;

	// profile words live at base + 16*idx: lo, hi, phase
	genvar gi;
	generate
		for (gi = 0; gi < `DDSUL_NPROF; gi++) begin : g_prof
			always_ff @(posedge core_clk) begin
				if (srst) begin
					prof_f_q[gi] <= '0;
					prof_p_q[gi] <= '0;
				end else if (clk_en && wr_go && s_axi_awaddr >= `DDSUL_A_PROF_BASE && !pidx_w[7]
						&& s_axi_awaddr[1:0] == 2'h0 && pidx_w[6:4] == 3'(gi)) begin // refused words must not land
					case (pidx_w[3:2])
						2'h0: prof_f_q[gi][31:0] <= s_axi_wdata;
						2'h1: prof_f_q[gi][47:32] <= s_axi_wdata[15:0];
						2'h2: prof_p_q[gi] <= s_axi_wdata[13:0];
						default: ;
					endcase
				end
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		logic       upd_now;
		logic       prof_now;
		logic       wmap;
		logic       rmap;
		logic [7:0] ridx;
		upd_now  = 1'b0;
		prof_now = 1'b0;
		wmap     = 1'b0;
		rmap     = 1'b0;
		ridx     = s_axi_araddr - `DDSUL_A_PROF_BASE;
		s_d = s_q;
		s_d.commit_p  = 1'b0;
		s_d.profile_p = 1'b0;

		// strobe and pins looked at only on sync edges
		if (sync_clk_rise) begin
			upd_now     = commit_strobe && !s_q.upd_s; // edge seen at sync edge
			prof_now    = s_q.prof_v && profile_select_pins != s_q.prof_s;
			s_d.upd_s   = commit_strobe;
			s_d.prof_s  = profile_select_pins;
			s_d.prof_v  = 1'b1;
		end

		// countdowns; count 1 means apply now
		if (s_q.cnt_c == 6'h01) begin
			s_d.dac_f    = s_q.pend_f;
			s_d.dac_p    = s_q.pend_p;
			s_d.commit_p = 1'b1;
		end
		if (s_q.cnt_c != 6'h00)
			s_d.cnt_c = s_q.cnt_c - 6'h01;
		if (s_q.cnt_p == 6'h01) begin
			s_d.dac_f     = prof_f_q[s_q.pend_idx];
			s_d.dac_p     = prof_p_q[s_q.pend_idx];
			s_d.profile_p = 1'b1;
		end
		if (s_q.cnt_p != 6'h00)
			s_d.cnt_p = s_q.cnt_p - 6'h01;
		if (s_q.cnt_s == 3'h1) begin
			s_d.cp   = s_q.pend_cp;
			s_d.step = s_q.pend_step;
			s_d.rate = s_q.pend_rate;
		end
		if (s_q.cnt_s != 3'h0)
			s_d.cnt_s = s_q.cnt_s - 3'h1;

		// a new event restarts its countdown; older pending one is superseded
		if (upd_now) begin
			s_d.cnt_c     = CL;
			s_d.cnt_s     = SL;
			s_d.pend_f    = s_q.sf;
			s_d.pend_p    = s_q.sp;
			s_d.pend_cp   = s_q.scp;
			s_d.pend_step = s_q.sstep;
			s_d.pend_rate = s_q.srate;
		end
		if (prof_now) begin
			s_d.cnt_p    = PL;
			s_d.pend_idx = profile_select_pins; // binary index
		end

		// write channel: address and data taken together
		if (wr_go) begin
			wmap = 1'b1;
			case (s_axi_awaddr)
				`DDSUL_A_FREQ_LO: s_d.sf[31:0] = s_axi_wdata;
				`DDSUL_A_FREQ_HI: s_d.sf[47:32] = s_axi_wdata[15:0];
				`DDSUL_A_PHASE:   s_d.sp = s_axi_wdata[13:0];
				`DDSUL_A_CP:      s_d.scp = s_axi_wdata[2:0];
				`DDSUL_A_STEP_LO: s_d.sstep[31:0] = s_axi_wdata;
				`DDSUL_A_STEP_HI: s_d.sstep[47:32] = s_axi_wdata[15:0];
				`DDSUL_A_RATE:    s_d.srate = s_axi_wdata[15:0];
				default:          wmap = s_axi_awaddr >= `DDSUL_A_PROF_BASE && pidx_w < 8'h80
					&& pidx_w[3:2] != 2'h3 && s_axi_awaddr[1:0] == 2'h0;
			endcase
			// byte strobes ignored: word writes only, limitation of this block
			s_d.bresp = wmap ? `DDSUL_RESP_OKAY : `DDSUL_RESP_SLVERR;
			s_d.wst   = ddsul_pkg::DDSUL_B_RESP;
		end else if (s_q.wst == ddsul_pkg::DDSUL_B_RESP && s_axi_bready)
			s_d.wst = ddsul_pkg::DDSUL_B_IDLE;

		// read channel, status shows live pipeline activity
		if (rd_go) begin
			rmap = 1'b1;
			case (s_axi_araddr)
				`DDSUL_A_FREQ_LO: s_d.rdata = s_q.dac_f[31:0];
				`DDSUL_A_FREQ_HI: s_d.rdata = {16'h0000, s_q.dac_f[47:32]};
				`DDSUL_A_PHASE:   s_d.rdata = {18'h00000, s_q.dac_p};
				`DDSUL_A_CP:      s_d.rdata = {29'h00000000, s_q.cp};
				`DDSUL_A_STEP_LO: s_d.rdata = s_q.step[31:0];
				`DDSUL_A_STEP_HI: s_d.rdata = {16'h0000, s_q.step[47:32]};
				`DDSUL_A_RATE:    s_d.rdata = {16'h0000, s_q.rate};
				`DDSUL_A_STATUS:  s_d.rdata = {25'h0000000, s_q.prof_s,
					s_q.cnt_s != 3'h0, s_q.cnt_p != 6'h00, s_q.cnt_c != 6'h00, s_q.upd_s};
				default: begin
					rmap = s_axi_araddr >= `DDSUL_A_PROF_BASE && ridx < 8'h80
						&& ridx[3:2] != 2'h3 && s_axi_araddr[1:0] == 2'h0;
					case (ridx[3:2])
						2'h0:    s_d.rdata = prof_f_q[ridx[6:4]][31:0];
						2'h1:    s_d.rdata = {16'h0000, prof_f_q[ridx[6:4]][47:32]};
						2'h2:    s_d.rdata = {18'h00000, prof_p_q[ridx[6:4]]};
						default: s_d.rdata = 32'h00000000;
					endcase
					if (!rmap)
						s_d.rdata = 32'h00000000;
				end
			endcase
			s_d.rresp = rmap ? `DDSUL_RESP_OKAY : `DDSUL_RESP_SLVERR;
			s_d.rst   = ddsul_pkg::DDSUL_B_RESP;
		end else if (s_q.rst == ddsul_pkg::DDSUL_B_RESP && s_axi_rready)
			s_d.rst = ddsul_pkg::DDSUL_B_IDLE;
	end

	// ----------------------------------------------------------------
	// state register, frozen while clk_en low
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (srst) begin
			s_q     <= '0;
			s_q.cp  <= `DDSUL_CP_RST;
			s_q.wst <= ddsul_pkg::DDSUL_B_IDLE;
			s_q.rst <= ddsul_pkg::DDSUL_B_IDLE;
		end else if (clk_en)
			s_q <= s_d;
	end

	// ready flags kept in their own flops so the ports need no decode logic
	logic awr_q;
	logic arr_q;
	always_ff @(posedge core_clk) begin
		if (srst) begin
			awr_q <= 1'b1;
			arr_q <= 1'b1;
		end else if (clk_en) begin
			awr_q <= s_d.wst == ddsul_pkg::DDSUL_B_IDLE;
			arr_q <= s_d.rst == ddsul_pkg::DDSUL_B_IDLE;
		end
	end

	// outputs straight from flops
	// response state code is the only one with bit 0 set
	assign s_axi_awready     = awr_q;
	assign s_axi_wready      = awr_q;
	assign s_axi_bvalid      = s_q.wst[0];
	assign s_axi_bresp       = s_q.bresp;
	assign s_axi_arready     = arr_q;
	assign s_axi_rvalid      = s_q.rst[0];
	assign s_axi_rdata       = s_q.rdata;
	assign s_axi_rresp       = s_q.rresp;
	assign dac_freq          = s_q.dac_f;
	assign dac_phase         = s_q.dac_p;
	assign charge_pump_output = s_q.cp;
	assign sweep_step        = s_q.step;
	assign sweep_rate        = s_q.rate;
	assign commit_applied    = s_q.commit_p;
	assign profile_applied   = s_q.profile_p;
endmodule // ddsul_top

// >>> verif/ddsul_ctrl_model.sv
// external controller model: sync edge marker, commit strobe and profile pins
// assumes sync clock is a quarter of core_clk and the bench sets the requests
`timescale 1ns/100ps
module ddsul_ctrl_model (
	input  wire logic       core_clk,
	input  wire logic       srst,
	input  wire logic       req_commit,
	input  wire logic       req_glitch,
	input  wire logic [2:0] req_prof,
	output logic            sync_clk_rise,
	output logic            commit_strobe,
	output logic [2:0]      profile_select_pins
);
	// ----------------------------------------------------------------
	// sync divider and pin drive
	// ----------------------------------------------------------------
	logic [1:0] div_q;
	logic       lvl_q;
	logic       glt_q;
	// pins move only right after a sync edge so they stand a whole sync period
	always_ff @(posedge core_clk) begin
		if (srst) begin
			{div_q, lvl_q, glt_q, sync_clk_rise, profile_select_pins} <= '0;
		end else begin
			div_q <= div_q + 2'h1;
			sync_clk_rise <= (div_q == 2'h3);
			glt_q <= req_glitch && (div_q == 2'h0); // off-edge pulse, only when asked
			if (sync_clk_rise) begin
				lvl_q <= req_commit;
				profile_select_pins <= req_prof;
			end
		end
	end
	assign commit_strobe = lvl_q | glt_q;
endmodule // ddsul_ctrl_model

// >>> verif/ddsul_monitor.sv
// checker on the ports of the update latency pipeline
// assumes one clock domain and a synchronous active-high reset
`timescale 1ns/100ps
`include "ddsul_cfg.svh"
module ddsul_monitor #(
	parameter int COMMIT_LAT  = 33,
	parameter int PROFILE_LAT = 29,
	parameter int SHORT_LAT   = 4
) (
	input wire logic                     core_clk,
	input wire logic                     srst,
	input wire logic                     clk_en,
	input wire logic                     sync_clk_rise,
	input wire logic                     commit_strobe,
	input wire logic [`DDSUL_PROF_W-1:0] profile_select_pins,
	input wire logic                     s_axi_awvalid,
	input wire logic                     s_axi_wvalid,
	input wire logic                     s_axi_awready,
	input wire logic                     s_axi_bvalid,
	input wire logic [`DDSUL_FREQ_W-1:0] dac_freq,
	input wire logic [`DDSUL_PHASE_W-1:0] dac_phase,
	input wire logic [`DDSUL_CP_W-1:0]   charge_pump_output,
	input wire logic [`DDSUL_STEP_W-1:0] sweep_step,
	input wire logic [`DDSUL_RATE_W-1:0] sweep_rate,
	input wire logic                     commit_applied,
	input wire logic                     profile_applied
);
	// ----------------------------------------------------------------
	// reference countdowns
	// ----------------------------------------------------------------
	logic       s_q, v_q;
	logic [2:0] p_q;
	logic [5:0] cc_q, pc_q, sc_q;
	wire c_det = sync_clk_rise && clk_en && commit_strobe && !s_q;
	wire p_det = sync_clk_rise && clk_en && v_q && (profile_select_pins != p_q);
	// a new event restarts its countdown, as the pending value is replaced
	always_ff @(posedge core_clk) begin
		if (srst) begin
			{s_q, v_q, p_q, cc_q, pc_q, sc_q} <= '0;
		end else if (clk_en) begin
			if (sync_clk_rise) begin
				{s_q, v_q, p_q} <= {commit_strobe, 1'b1, profile_select_pins};
			end
			cc_q <= c_det ? 6'(COMMIT_LAT) : cc_q - 6'(cc_q != 6'h00);
			pc_q <= p_det ? 6'(PROFILE_LAT) : pc_q - 6'(pc_q != 6'h00);
			sc_q <= c_det ? 6'(SHORT_LAT) : sc_q - 6'(sc_q != 6'h00);
		end
	end
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (srst);
	property p_cmt_land; (cc_q == 6'h01 && pc_q != 6'h01) |=> commit_applied; endproperty
	property p_cmt_only; commit_applied |-> $past(cc_q) == 6'h01; endproperty
	property p_prf_land; (pc_q == 6'h01) |=> profile_applied; endproperty
	property p_prf_only; profile_applied |-> $past(pc_q) == 6'h01; endproperty
	property p_dac_hold; !(commit_applied || profile_applied) |-> $stable(dac_freq) && $stable(dac_phase); endproperty
	property p_cp_hold; ($past(sc_q) != 6'h01) |-> $stable(charge_pump_output); endproperty
	property p_swp_hold; ($past(sc_q) != 6'h01) |-> $stable(sweep_step) && $stable(sweep_rate); endproperty
	property p_wr_ans; (s_axi_awvalid && s_axi_wvalid && s_axi_awready) |=> s_axi_bvalid; endproperty
	a_cmt_land: assert property (p_cmt_land) else $error("commit not applied on time");
	a_cmt_only: assert property (p_cmt_only) else $error("commit applied at wrong time");
	a_prf_land: assert property (p_prf_land) else $error("profile not applied on time");
	a_prf_only: assert property (p_prf_only) else $error("profile applied at wrong time");
	a_dac_hold: assert property (p_dac_hold) else $error("dac value moved without apply");
	a_cp_hold: assert property (p_cp_hold) else $error("scaler moved off its slot");
	a_swp_hold: assert property (p_swp_hold) else $error("sweep moved off its slot");
	a_wr_ans: assert property (p_wr_ans) else $error("write response late");
	c_cmt: cover property (commit_applied);
	c_prf: cover property (profile_applied);
	c_cp: cover property ($past(sc_q) == 6'h01 && $changed(charge_pump_output));
endmodule // ddsul_monitor

bind ddsul_top ddsul_monitor #(.COMMIT_LAT(COMMIT_LAT), .PROFILE_LAT(PROFILE_LAT), .SHORT_LAT(SHORT_LAT)) u_mon (
	.core_clk, .srst, .clk_en, .sync_clk_rise, .commit_strobe, .profile_select_pins, .s_axi_awvalid,
	.s_axi_wvalid, .s_axi_awready, .s_axi_bvalid, .dac_freq, .dac_phase, .charge_pump_output,
	.sweep_step, .sweep_rate, .commit_applied, .profile_applied);

// >>> verif/ddsul_tb.sv
// self-checking bench: AXI4-Lite master tasks plus controller model
// assumes default latencies and a sync clock at a quarter of core_clk
`timescale 1ns/100ps
`include "ddsul_cfg.svh"
module testbench;
	// ----------------------------------------------------------------
	// signals, clock and tasks
	// ----------------------------------------------------------------
	localparam int CL = 33;
	localparam int PL = 29;
	logic        core_clk = 1'b0, srst = 1'b1, req_commit = 1'b0, req_glitch = 1'b0, clk_en = 1'b1;
	logic [2:0]  req_prof = 3'h0;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic        sync_clk_rise, commit_strobe, commit_applied, profile_applied;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rr;
	logic [2:0]  profile_select_pins, charge_pump_output;
	logic [47:0] dac_freq, sweep_step;
	logic [13:0] dac_phase;
	logic [15:0] sweep_rate;
	logic [31:0] wv [7] = '{32'h89AB_CDEF, 32'h4567, 32'h1ABC, 32'h5, 32'h2, 32'h3, 32'hC8};
	int          failures = 0, tests_run = 0;
	always #50 core_clk = ~core_clk;
	ddsul_top #(.COMMIT_LAT(CL), .PROFILE_LAT(PL), .SHORT_LAT(4)) dut (.core_clk, .srst, .clk_en,
		.sync_clk_rise, .commit_strobe, .profile_select_pins, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
		.s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_bvalid, .s_axi_bready,
		.s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready,
		.s_axi_rdata, .s_axi_rresp, .dac_freq, .dac_phase, .charge_pump_output, .sweep_step, .sweep_rate,
		.commit_applied, .profile_applied);
	ddsul_ctrl_model u_ctrl (.core_clk, .srst, .req_commit, .req_glitch, .req_prof, .sync_clk_rise,
		.commit_strobe, .profile_select_pins);
	task automatic chk(input logic [63:0] s, input logic [63:0] e);
		tests_run++;
		if (s !== e) begin
			failures++;
			$display("MISMATCH t=%0t seen %h exp %h", $time, s, e);
		end
	endtask
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = `DDSUL_RESP_OKAY);
		@(posedge core_clk);
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		{s_axi_awaddr, s_axi_wdata} <= {a, d};
		do @(posedge core_clk); while (s_axi_awready !== 1'b1);
		chk(64'(s_axi_wready), 64'h1);
		{s_axi_awvalid, s_axi_wvalid} <= 2'h0;
		do @(posedge core_clk); while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
		chk(64'(s_axi_bresp), 64'(er));
	endtask
	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge core_clk);
		{s_axi_arvalid, s_axi_rready, s_axi_araddr} <= {2'h3, a};
		do @(posedge core_clk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do @(posedge core_clk); while (s_axi_rvalid !== 1'b1);
		{d, r} = {s_axi_rdata, s_axi_rresp};
		s_axi_rready <= 1'b0;
	endtask
	// edges from the detecting sync edge until the apply pulse is seen
	task automatic lat(input logic prof, input int n_exp);
		int n;
		n = 0;
		do @(posedge core_clk);
		while (!(sync_clk_rise && (prof ? profile_select_pins === req_prof : commit_strobe === 1'b1)));
		do begin
			@(posedge core_clk);
			n++;
		end while ((prof ? profile_applied : commit_applied) !== 1'b1);
		chk(64'(n), 64'(n_exp));
	endtask
	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	// watchdog: whole run is well under a thousand cycles
	initial begin
		repeat (20000) @(posedge core_clk);
		failures++;
		report_and_stop();
	end
	initial begin
		repeat (6) @(posedge core_clk);
		srst <= 1'b0;
		@(posedge core_clk);
		chk({dac_freq, 13'h0, charge_pump_output}, 64'h0);
		for (int i = 0; i < 7; i++) axi_wr(8'(4 * i), wv[i]);
		chk(64'(dac_freq), 64'h0);
		req_commit <= 1'b1;
		lat(1'b0, CL + 1);
		req_commit <= 1'b0;
		chk(64'(dac_freq), 64'h4567_89AB_CDEF);
		chk(64'(dac_phase), 64'h1ABC);
		chk(64'(charge_pump_output), 64'h5);
		chk({sweep_step, sweep_rate}, 64'h0003_0000_0002_00C8);
		axi_rd(8'h00, rd, rr);
		chk({30'h0, rd, rr}, {30'h0, 32'h89AB_CDEF, `DDSUL_RESP_OKAY});
		axi_rd(8'h30, rd, rr);
		chk({30'h0, rd, rr}, {62'h0, `DDSUL_RESP_SLVERR});
		axi_wr(8'h30, 32'h0, `DDSUL_RESP_SLVERR);
		// strobe pulse between sync edges must not commit
		axi_wr(8'h00, 32'h1);
		req_glitch <= 1'b1;
		repeat (8) @(posedge core_clk);
		req_glitch <= 1'b0;
		repeat (45) @(posedge core_clk);
		chk(64'(dac_freq), 64'h4567_89AB_CDEF);
		for (int n = 0; n < 8; n++) begin
			axi_wr(8'(64 + 16 * n), 32'h1111_0000 + 32'(n));
			axi_wr(8'(68 + 16 * n), 32'h0A00 + 32'(n));
			axi_wr(8'(72 + 16 * n), 32'h0200 + 32'(n));
		end
		// misaligned word is refused and must leave profile 0 untouched
		axi_wr(8'h41, 32'hDEAD_BEEF, `DDSUL_RESP_SLVERR);
		for (int n = 1; n < 9; n++) begin
			req_prof <= 3'(n);
			lat(1'b1, PL + 1);
			chk(64'(dac_freq), {16'h0, 16'h0A00 + 16'(n % 8), 32'h1111_0000 + 32'(n % 8)});
			chk(64'(dac_phase), 64'h0200 + 64'(n % 8));
			axi_rd(`DDSUL_A_STATUS, rd, rr);
			chk({30'h0, rd, rr}, {30'h0, 25'h0, 3'(n % 8), 4'h0, `DDSUL_RESP_OKAY});
		end
		// pins move while frozen: nothing may apply until the enable returns
		clk_en <= 1'b0;
		req_prof <= 3'h3;
		repeat (40) @(posedge core_clk);
		chk(64'(dac_freq), 64'h0A00_1111_0000);
		clk_en <= 1'b1;
		lat(1'b1, PL + 1);
		chk(64'(dac_freq), 64'h0A03_1111_0003);
		report_and_stop();
	end
endmodule // testbench
